// *** src/fbp_pkg.sv ***
// Shared constants, enumerations and carriers for the flash bus pin interface
package fbp_pkg;

	// ==========================================================================
	// Widths (largest density: 25 array address bits plus the die select bit)
	localparam int ADDR_W      = 25;
	localparam int PIN_ADDR_W  = 26;
	localparam int TOP_DIE_BIT = 25;
	localparam int DATA_W      = 16;
	localparam int NUM_BLK     = 8;
	localparam int BLK_W       = 3;
	localparam int BLK_LSB     = 22;
	localparam int FIFO_DEPTH  = 16;

	// ==========================================================================
	// Read configuration register fields and reset value
	localparam int           RCR_HOLD_POL_BIT = 10;
	localparam int           RCR_ASYNC_BIT    = 15;
	localparam logic [15:0]  RCR_RESET        = 16'h8000;

	// ==========================================================================
	// Status register fields and reset value
	localparam logic [7:0] STATUS_RESET = 8'h80;
	localparam int         ST_READY     = 7;
	localparam int         ST_ERASE_ERR = 5;
	localparam int         ST_PROG_ERR  = 4;
	localparam int         ST_VPP_ERR   = 3;
	localparam int         ST_LOCK_ERR  = 1;

	// ==========================================================================
	// Command codes on the low data byte
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] CMD_READ_CFG     = 8'h90;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM      = 8'h40;
	localparam logic [7:0] CMD_ERASE        = 8'h20;
	localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
	localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
	localparam logic [7:0] CMD_LOCK         = 8'h01;
	localparam logic [7:0] CMD_LOCKDOWN     = 8'h2f;
	localparam logic [7:0] CMD_SET_RCR      = 8'h03;

	// ==========================================================================
	// Timing: link clock edges of hold before the first burst word; block lock state at reset
	localparam logic [2:0] BURST_LATENCY = 3'h4;
	localparam logic       LOCK_RESET    = 1'b1;

	// ==========================================================================
	// Types
	typedef enum logic [1:0] {
		CS_IDLE      = 2'b00,
		CS_PROG_DATA = 2'b01,
		CS_ERASE_CNF = 2'b10,
		CS_LOCK_SEL  = 2'b11
	} fbp_cmd_state_e;

	typedef enum logic [1:0] {
		RD_ARRAY  = 2'b00,
		RD_STATUS = 2'b01,
		RD_CFG    = 2'b10
	} fbp_read_mode_e;

	typedef enum logic {
		OP_PROGRAM = 1'b0,
		OP_ERASE   = 1'b1
	} fbp_op_e;

	typedef struct packed {
		logic [PIN_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]     dq;
		logic                  address_latch_strobe_n;
		logic                  die_select_n;
		logic                  die_output_enable_n;
		logic                  write_strobe_n;
		logic                  link_clk;
		logic                  pin_reset_n;
		logic                  write_protect_n;
		logic                  prog_supply_ok;
	} fbp_pin_in_s;

	typedef struct packed {
		fbp_op_e           op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fbp_array_op_s;

endpackage

// *** src/fbp_sync.sv ***
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module fbp_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;

	// First stage feeds only the second
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// *** src/fbp_fifo.sv ***
// Operation FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module fbp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0]  mem_ff [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [PW:0]   count_ff;

	// Handshake decode
	wire push  = in_valid && in_ready;
	wire load  = !out_valid || out_ready;
	wire pop   = load && (count_ff != '0);
	assign in_ready = (count_ff != (PW+1)'(DEPTH));

	// Storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// Pointers, count and output stage
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
			count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
			if (load) out_valid <= pop;
			if (pop) out_data <= mem_ff[rd_ptr_ff];
		end
	end
endmodule
`default_nettype wire

// *** src/fbp_flash_if.sv ***
// Device-side pin interface of a 16-bit parallel NOR flash
// Notes on behaviour
// [R1] Address bus holds 25 array bits, the 512-Mbit width.
// [R2] Topmost address bit high selects the top-parameter die.
// [R3] Data bus takes commands and data on writes, returns array, status, config reads.
// [R4] Data lines float whenever die select or output enable is inactive.
// [R5] Synchronous mode latches address on strobe rise or first clock edge with strobe low.
// [R6] Asynchronous mode latches on strobe rise; address flows through while strobe low.
// [R7] Link clock is used only in synchronous read mode.
// [R8] Die select inactive means standby; data and hold indicator float.
// [R9] Host keeps die select high when not accessing the device.
// [R10] Output enable low drives data; high floats data and hold indicator.
// [R11] Reset pin low resets automation and blocks all writes.
// [R12] Leaving reset enters asynchronous array read mode.
// [R13] Config register bit 10 sets the asserted level of the hold indicator.
// [R14] Hold indicator driven only while die select and output enable are low.
// [R15] In burst reads hold is asserted while data is invalid.
// [R16] Hold stays deasserted in asynchronous reads and all writes.
// [R17] Address and data are latched at the write strobe rising edge.
// [R18] Write protect low enables lock-down; locked-down blocks ignore unlock.
// [R19] Write protect high overrides lock-down so blocks can be unlocked and altered.
// [R20] Program supply at lockout level refuses any change to memory.
// [R21] Write latches on whichever of write strobe or die select rises first.
// [R22] Host asserts die select and write strobe with reset and output enable inactive.
// [R23] Status reads 0x80 after power-up or reset.
// [R24] Program supply is one input flag; program and erase while low are rejected.
// [R25] Hold polarity defaults to active low until config register is written.
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_if
	import fbp_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire fbp_pin_in_s         pins,
	output logic      [DATA_W-1:0]   dq_out_ff,
	output logic                     dq_oe_n_ff,
	output logic                     hold_ff,
	output logic                     hold_oe_n_ff,
	output logic                     top_die_sel_ff,
	output logic      [ADDR_W-1:0]   array_rd_addr_ff,
	input  wire logic [DATA_W-1:0]   array_rd_data,
	output logic                     op_valid,
	input  wire logic                op_ready,
	output fbp_array_op_s            op_data
);
	// ==========================================================================
	// Pin synchronisation and edge detection
	fbp_pin_in_s pin_s;
	fbp_pin_in_s pin_q_ff;

	fbp_sync #(
		.W ($bits(fbp_pin_in_s))
	) u_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.d        (pins),
		.q        (pin_s)
	);

	// Previous sample, for edges and for the last value of a write cycle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pin_q_ff <= '0;
		end else begin
			pin_q_ff <= pin_s;
		end
	end

	logic [15:0]     rcr_ff;
	fbp_cmd_state_e  cmd_st_ff;
	fbp_read_mode_e  rd_mode_ff;
	logic [6:0]      err_ff;
	logic            pend_valid_ff;
	fbp_array_op_s   pend_op_ff;
	logic [PIN_ADDR_W-1:0] lat_addr_ff;
	logic            sync_cap_ff;
	logic [2:0]      wait_cnt_ff;
	logic            wr_act_ff;
	logic [NUM_BLK-1:0] lock_ff;
	logic [NUM_BLK-1:0] lkdn_ff;

	// Decoded pin conditions
	wire rst_act   = !pin_s.pin_reset_n;
	wire sync_mode = !rcr_ff[RCR_ASYNC_BIT];
	wire hold_pol  = rcr_ff[RCR_HOLD_POL_BIT];
	wire clk_rise  = pin_s.link_clk && !pin_q_ff.link_clk;
	wire adv_low   = !pin_s.address_latch_strobe_n;
	wire adv_rise  = pin_s.address_latch_strobe_n && !pin_q_ff.address_latch_strobe_n;
	wire sel_out   = !pin_s.die_select_n && !pin_s.die_output_enable_n && !rst_act;
	wire read_sel  = sel_out && pin_s.write_strobe_n;

	// ==========================================================================
	// Address latch and burst sequencing
	wire sync_clk_cap = sync_mode && clk_rise && adv_low && !sync_cap_ff;
	wire sync_adv_cap = sync_mode && adv_rise && !sync_cap_ff;
	wire burst_step   = sync_mode && clk_rise && read_sel && !sync_clk_cap
	                    && (wait_cnt_ff == '0);
	wire burst_wait   = sync_mode && read_sel && (wait_cnt_ff != '0 || sync_clk_cap || sync_adv_cap);
	wire [ADDR_W-1:0] next_word = lat_addr_ff[ADDR_W-1:0] + 1'b1;

	// Latch follows the strobe; the link clock matters only in sync mode
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			lat_addr_ff <= '0;
			sync_cap_ff <= 1'b0;
		end else begin
			if (!sync_mode && adv_low) begin
				lat_addr_ff <= pin_s.addr; // R6
			end else if (sync_clk_cap) begin
				lat_addr_ff <= pin_s.addr; // R5
			end else if (sync_adv_cap) begin
				lat_addr_ff <= pin_q_ff.addr; // R5
			end else if (burst_step) begin
				lat_addr_ff[ADDR_W-1:0] <= next_word; // R7
			end
			if (!adv_low) sync_cap_ff <= 1'b0;
			else if (sync_clk_cap) sync_cap_ff <= 1'b1;
		end
	end

	// First-word latency counted in link clock edges
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wait_cnt_ff <= '0;
		end else if (rst_act || !sync_mode) begin
			wait_cnt_ff <= '0;
		end else if (sync_clk_cap || sync_adv_cap) begin
			wait_cnt_ff <= BURST_LATENCY; // R15
		end else if (clk_rise && read_sel && wait_cnt_ff != '0) begin
			wait_cnt_ff <= wait_cnt_ff - 1'b1; // R15
		end
	end

	// ==========================================================================
	// Read data path and output drivers
	wire [7:0]  status_word = {!pend_valid_ff, err_ff};
	wire [15:0] rd_word = (rd_mode_ff == RD_STATUS) ? {8'h00, status_word} :
	                      (rd_mode_ff == RD_CFG)    ? rcr_ff : array_rd_data; // R3

	// Drive data only while selected and output-enabled; hold follows polarity
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dq_out_ff        <= '0;
			dq_oe_n_ff       <= 1'b1;
			hold_ff          <= 1'b1;
			hold_oe_n_ff     <= 1'b1;
			top_die_sel_ff   <= 1'b0;
			array_rd_addr_ff <= '0;
		end else begin
			dq_out_ff        <= rd_word; // R3
			dq_oe_n_ff       <= !read_sel; // R4 R8 R10
			hold_oe_n_ff     <= !sel_out; // R14 R8 R10
			hold_ff          <= burst_wait ? hold_pol : !hold_pol; // R13 R15 R16
			top_die_sel_ff   <= lat_addr_ff[TOP_DIE_BIT]; // R2
			array_rd_addr_ff <= lat_addr_ff[ADDR_W-1:0]; // R1
		end
	end

	// ==========================================================================
	// Write cycle capture: ends at the first of write strobe or select rising
	wire wr_act = !pin_s.die_select_n && !pin_s.write_strobe_n && !rst_act; // R11 R22
	wire wr_end = wr_act_ff && !wr_act && !rst_act; // R17 R21
	wire [ADDR_W-1:0] wr_addr = pin_q_ff.addr[ADDR_W-1:0];
	wire [DATA_W-1:0] wr_data = pin_q_ff.dq;
	wire [7:0]        cmd     = wr_data[7:0];
	wire [BLK_W-1:0]  blk     = wr_addr[BLK_LSB +: BLK_W];

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_act_ff <= 1'b0;
		end else begin
			wr_act_ff <= wr_act;
		end
	end

	// Array operation checks
	wire vpp_bad    = !pin_s.prog_supply_ok; // R20 R24
	wire blk_locked = lock_ff[blk];
	wire op_cmd     = wr_end && ((cmd_st_ff == CS_PROG_DATA)
	                  || (cmd_st_ff == CS_ERASE_CNF && cmd == CMD_CONFIRM));
	wire op_is_ers  = (cmd_st_ff == CS_ERASE_CNF);
	wire op_ok      = op_cmd && !vpp_bad && !blk_locked && !pend_valid_ff;
	wire op_fail    = op_cmd && !op_ok;
	wire seq_bad    = wr_end && (cmd_st_ff == CS_ERASE_CNF) && (cmd != CMD_CONFIRM);
	wire lock_cyc   = wr_end && (cmd_st_ff == CS_LOCK_SEL);
	wire idle_cyc   = wr_end && (cmd_st_ff == CS_IDLE);

	// ==========================================================================
	// Command sequencer
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cmd_st_ff  <= CS_IDLE;
			rd_mode_ff <= RD_ARRAY;
		end else if (rst_act) begin
			cmd_st_ff  <= CS_IDLE; // R11
			rd_mode_ff <= RD_ARRAY; // R12
		end else if (wr_end) begin
			cmd_st_ff <= CS_IDLE;
			unique case (cmd_st_ff)
				CS_IDLE: begin
					if (cmd == CMD_READ_ARRAY) rd_mode_ff <= RD_ARRAY;
					if (cmd == CMD_READ_STATUS) rd_mode_ff <= RD_STATUS;
					if (cmd == CMD_READ_CFG) rd_mode_ff <= RD_CFG;
					if (cmd == CMD_PROGRAM) begin
						cmd_st_ff  <= CS_PROG_DATA;
						rd_mode_ff <= RD_STATUS;
					end
					if (cmd == CMD_ERASE) begin
						cmd_st_ff  <= CS_ERASE_CNF;
						rd_mode_ff <= RD_STATUS;
					end
					if (cmd == CMD_LOCK_SETUP) cmd_st_ff <= CS_LOCK_SEL;
				end
				CS_PROG_DATA, CS_ERASE_CNF: begin
					rd_mode_ff <= RD_STATUS;
				end
				CS_LOCK_SEL: begin
					rd_mode_ff <= RD_ARRAY;
				end
			endcase
		end
	end

	// Error bits in status; a new error wins over a clear in the same cycle
	wire [6:0] err_set = {1'b0,
		(op_fail && op_is_ers) || seq_bad,
		op_fail && !op_is_ers,
		op_fail && vpp_bad,
		1'b0,
		op_fail && blk_locked,
		1'b0};
	wire err_clr = idle_cyc && (cmd == CMD_CLEAR_STATUS);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			err_ff <= STATUS_RESET[6:0]; // R23
		end else if (rst_act) begin
			err_ff <= STATUS_RESET[6:0]; // R23
		end else begin
			err_ff <= (err_clr ? 7'h00 : err_ff) | err_set; // R20 R24
		end
	end

	// Read configuration register; config write carried on the address lines
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rcr_ff <= RCR_RESET; // R25
		end else if (rst_act) begin
			rcr_ff <= RCR_RESET; // R12 R25
		end else if (lock_cyc && cmd == CMD_SET_RCR) begin
			rcr_ff <= wr_addr[15:0]; // R13
		end
	end

	// ==========================================================================
	// Per-block lock and lock-down bits
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BLK; gi++) begin : g_blk
			wire hit      = lock_cyc && (blk == BLK_W'(gi));
			wire do_lock  = hit && (cmd == CMD_LOCK || cmd == CMD_LOCKDOWN);
			wire do_lkdn  = hit && (cmd == CMD_LOCKDOWN);
			wire do_unlk  = hit && (cmd == CMD_CONFIRM)
			                && !(lkdn_ff[gi] && !pin_s.write_protect_n); // R18 R19

			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					lock_ff[gi] <= LOCK_RESET;
					lkdn_ff[gi] <= 1'b0;
				end else if (rst_act) begin
					lock_ff[gi] <= LOCK_RESET;
					lkdn_ff[gi] <= 1'b0;
				end else begin
					if (do_lock) lock_ff[gi] <= 1'b1;
					else if (do_unlk) lock_ff[gi] <= 1'b0; // R18 R19
					if (do_lkdn) lkdn_ff[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// ==========================================================================
	// Pending operation handed to the FIFO; busy while it waits for room
	wire pend_ready;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pend_valid_ff <= 1'b0;
			pend_op_ff    <= '0;
		end else if (rst_act) begin
			pend_valid_ff <= 1'b0; // R11
		end else if (op_ok) begin
			pend_valid_ff   <= 1'b1; // R17
			pend_op_ff.op   <= op_is_ers ? OP_ERASE : OP_PROGRAM;
			pend_op_ff.addr <= wr_addr;
			pend_op_ff.data <= wr_data;
		end else if (pend_ready) begin
			pend_valid_ff <= 1'b0;
		end
	end

	fbp_fifo #(
		.W     ($bits(fbp_array_op_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (pend_valid_ff),
		.in_data   (pend_op_ff),
		.in_ready  (pend_ready),
		.out_valid (op_valid),
		.out_ready (op_ready),
		.out_data  (op_data)
	);

	// ==========================================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_wr_close;
		wr_act_ff ##1 !wr_act;
	endsequence

	sequence s_prog_low_vpp;
		(cmd_st_ff == CS_PROG_DATA) && wr_end && vpp_bad;
	endsequence

	dq_float_a: assert property ((pin_s.die_select_n || pin_s.die_output_enable_n)
		|=> dq_oe_n_ff) // R4
		else $error("data driven while deselected");

	hold_drive_a: assert property (sel_out |=> !hold_oe_n_ff ##0 !dq_oe_n_ff
		|| !$past(pin_s.write_strobe_n)) // R14
		else $error("hold indicator not driven while selected");

	hold_idle_a: assert property (!sync_mode |=> hold_ff == !$past(hold_pol)) // R16
		else $error("hold asserted outside burst");

	hold_burst_a: assert property ((sync_clk_cap && read_sel) ##1 read_sel
		|-> hold_ff == hold_pol) // R15
		else $error("hold not asserted at burst start");

	async_flow_a: assert property ((!sync_mode && adv_low) |=>
		lat_addr_ff == $past(pin_s.addr)) // R6
		else $error("address did not flow through");

	sync_cap_a: assert property (sync_clk_cap |=> lat_addr_ff == $past(pin_s.addr)
		##1 sync_cap_ff) // R5
		else $error("sync address not captured");

	reset_block_a: assert property (rst_act |=> !pend_valid_ff
		&& status_word == STATUS_RESET && rd_mode_ff == RD_ARRAY) // R11
		else $error("reset did not clear state");

	vpp_reject_a: assert property (s_prog_low_vpp |=> !pend_valid_ff
		&& err_ff[ST_VPP_ERR] && err_ff[ST_PROG_ERR]) // R24
		else $error("program accepted at low supply");

	lockdown_a: assert property ((lock_cyc && cmd == CMD_CONFIRM && lkdn_ff[blk]
		&& !pin_s.write_protect_n) |=> lock_ff[$past(blk)]) // R18
		else $error("locked-down block was unlocked");

	write_latch_a: assert property (s_wr_close ##0 op_ok |=>
		pend_op_ff.data == $past(pin_q_ff.dq)) // R17
		else $error("write data not latched at close");

endmodule
`default_nettype wire

// *** test/fbp_host_model.sv ***
// Host bus model that drives the flash pins the way a memory controller does
`timescale 1ns/1ps
`default_nettype none
module fbp_host_model
	import fbp_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic [DATA_W-1:0] dq_out,
	input  wire logic              dq_oe_n,
	output var  fbp_pin_in_s       pins
);
	fbp_pin_in_s drive;
	logic        drv;

	// Data wire: host, device, or the inverse of the last host word when nobody drives
	always_comb begin
		pins    = drive;
		pins.dq = drv ? drive.dq : (!dq_oe_n ? dq_out : ~drive.dq);
	end

	// Idle bus: deselected, link clock still, writes and reset inactive
	initial begin
		drive                     = '0;
		drive.die_select_n        = 1'b1;
		drive.die_output_enable_n = 1'b1;
		drive.write_strobe_n      = 1'b1;
		drive.pin_reset_n         = 1'b1;
		drive.write_protect_n     = 1'b1;
		drive.prog_supply_ok      = 1'b1;
		drv                       = 1'b0;
	end

	// Moves just past the n-th rising edge, where all pin changes happen
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Select and output enable, set together one edge later
	task automatic sel(input logic s, input logic o);
		step(1);
		drive.die_select_n        = s;
		drive.die_output_enable_n = o;
	endtask

	// Write cycle; cs_first ends it by deselecting before the strobe rises
	task automatic wr(input logic [PIN_ADDR_W-1:0] ad, input logic [DATA_W-1:0] d,
		input logic cs_first);
		step(1);
		drive.addr                = ad;
		drive.dq                  = d;
		drv                       = 1'b1;
		drive.die_output_enable_n = 1'b1;
		drive.die_select_n        = 1'b0;
		drive.write_strobe_n      = 1'b0;
		step(4);
		if (cs_first)
			drive.die_select_n = 1'b1;
		else
			drive.write_strobe_n = 1'b1;
		step(1);
		drive.die_select_n   = 1'b1;
		drive.write_strobe_n = 1'b1;
		drv                  = 1'b0;
		step(6);
	endtask

	// Asynchronous read: hold the address, sample once settled, release
	task automatic rd(input logic [PIN_ADDR_W-1:0] ad, output logic [DATA_W-1:0] q);
		drive.addr = ad;
		sel(1'b0, 1'b0);
		step(8);
		q = dq_out;
		sel(1'b1, 1'b1);
		step(4);
	endtask

	// One 160 ns link clock period, ending in the middle of the low phase
	task automatic lpulse();
		step(10);
		drive.link_clk = 1'b1;
		step(20);
		drive.link_clk = 1'b0;
		step(10);
	endtask
endmodule
`default_nettype wire

// *** test/fbp_flash_if_test.sv ***
// Self-checking bench for the flash pin interface
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_if_test
	import fbp_pkg::*;
;
	logic              core_clk  = 1'b0;
	logic              reset     = 1'b1;
	logic              op_ready  = 1'b0;
	fbp_pin_in_s       pins;
	logic [DATA_W-1:0] dq_out_ff;
	wire  logic [15:0] array_rd_data;
	logic              dq_oe_n_ff;
	logic              hold_ff;
	logic              hold_oe_n_ff;
	logic              top_die_sel_ff;
	logic              op_valid;
	logic [ADDR_W-1:0] array_rd_addr_ff;
	fbp_array_op_s     op_data;
	logic [41:0]       exp_q[$];
	logic [41:0]       e;
	logic [41:0]       s;
	logic [15:0]       v;
	logic [15:0]       d;
	logic [25:0]       a;
	int                n_fail    = 0;
	int                tests_run = 0;
	int                n;

	// Clock and array stand-in
	always #2 core_clk = ~core_clk;
	assign array_rd_data = array_rd_addr_ff[15:0] ^ 16'h3c3c;

	fbp_flash_if uut (.core_clk(core_clk), .reset(reset), .pins(pins),
		.dq_out_ff(dq_out_ff), .dq_oe_n_ff(dq_oe_n_ff), .hold_ff(hold_ff),
		.hold_oe_n_ff(hold_oe_n_ff), .top_die_sel_ff(top_die_sel_ff),
		.array_rd_addr_ff(array_rd_addr_ff), .array_rd_data(array_rd_data),
		.op_valid(op_valid), .op_ready(op_ready), .op_data(op_data));
	fbp_host_model host (.core_clk(core_clk), .dq_out(dq_out_ff), .dq_oe_n(dq_oe_n_ff),
		.pins(pins));

	// Expected array word, independent of the design
	function automatic logic [15:0] arr(input logic [24:0] a);
		return a[15:0] ^ 16'h3c3c;
	endfunction

	// Comparison, verdict and bus helpers
	task automatic check(input logic [41:0] seen, input logic [41:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmd(input logic [25:0] a, input logic [7:0] c);
		host.wr(a, {8'h00, c}, 1'b0);
	endtask

	task automatic prog(input logic [25:0] a, input logic [15:0] w);
		cmd(a, CMD_PROGRAM);
		host.wr(a, w, 1'b0);
	endtask

	task automatic ers(input logic [25:0] a, input logic [7:0] c);
		cmd(a, CMD_ERASE);
		cmd(a, c);
	endtask

	task automatic st(input logic [15:0] x);
		cmd(0, CMD_READ_STATUS);
		host.rd(0, v);
		check(v, x);
	endtask

	// Consumer side: every accepted op is matched with the oldest note
	always @(posedge core_clk) begin
		if (op_valid === 1'b1 && op_ready) begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : ~op_data;
			s = op_data;
			if (e[41])
				s[15:0] = e[15:0]; // erase data word is the confirm cycle, not compared
			check(s, e);
		end
	end

	// Watchdog, well past the expected run of some 2.4k cycles
	initial begin
		#200000;
		n_fail++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		report_and_stop();
	end

	// Test sequence
	initial begin
		void'($urandom(32'he722a6d0));
		repeat (4) @(posedge core_clk);
		#1 reset = 1'b0;
		op_ready = 1'b1;
		host.step(6);
		// Async reads: flow-through, latch on strobe rise, link clock ignored
		a = 26'($urandom);
		host.drive.addr = a;
		host.sel(0, 0);
		host.step(8);
		check(dq_out_ff, arr(a[24:0]));
		check(top_die_sel_ff, a[25]);
		check({hold_oe_n_ff, hold_ff}, 2'b01);
		a = ~a;
		host.drive.addr = a;
		host.lpulse();
		check({hold_ff, dq_out_ff}, {1'b1, arr(a[24:0])});
		host.drive.address_latch_strobe_n = 1'b1;
		host.step(6);
		host.drive.addr = ~a;
		host.step(8);
		check(dq_out_ff, arr(a[24:0]));
		check(top_die_sel_ff, a[25]);
		host.drive.address_latch_strobe_n = 1'b0;
		host.sel(0, 1);
		host.step(4);
		check({dq_oe_n_ff, hold_oe_n_ff}, 2'b11);
		host.sel(1, 0);
		host.step(4);
		check({dq_oe_n_ff, hold_oe_n_ff}, 2'b11);
		host.sel(1, 1);
		st(16'h0080);
		$display("test 1 done");
		// Locked block, low supply, bad confirm, then a program that passes
		prog(26'h10, 16'h1234);
		st(16'h0092);
		cmd(0, CMD_CLEAR_STATUS);
		cmd(0, CMD_LOCK_SETUP);
		host.wr(0, {8'h00, CMD_CONFIRM}, 1'b1);
		host.drive.prog_supply_ok = 1'b0;
		prog(26'h10, 16'h1234);
		st(16'h0098);
		cmd(0, CMD_CLEAR_STATUS);
		ers(26'h20, CMD_CONFIRM);
		st(16'h00a8);
		cmd(0, CMD_CLEAR_STATUS);
		host.drive.prog_supply_ok = 1'b1;
		ers(26'h20, CMD_READ_ARRAY);
		st(16'h00a0);
		cmd(0, CMD_CLEAR_STATUS);
		exp_q.push_back({OP_PROGRAM, 25'h10, 16'h5a5a});
		prog(26'h10, 16'h5a5a);
		host.step(10);
		st(16'h0080);
		$display("test 2 done");
		// Lock-down holds with write protect low, is overridden when high
		host.drive.write_protect_n = 1'b0;
		cmd(26'h400000, CMD_LOCK_SETUP);
		cmd(26'h400000, CMD_LOCKDOWN);
		cmd(26'h400000, CMD_LOCK_SETUP);
		cmd(26'h400000, CMD_CONFIRM);
		ers(26'h400000, CMD_CONFIRM);
		st(16'h00a2);
		cmd(0, CMD_CLEAR_STATUS);
		host.drive.write_protect_n = 1'b1;
		cmd(26'h400000, CMD_LOCK_SETUP);
		cmd(26'h400000, CMD_CONFIRM);
		exp_q.push_back({OP_ERASE, 25'h400000, 16'h0000});
		ers(26'h400000, CMD_CONFIRM);
		host.step(10);
		st(16'h0080);
		$display("test 3 done");
		// Fill the op buffer with the consumer stalled, refuse, then drain
		op_ready = 1'b0;
		n = 0;
		v = 16'h0080;
		while (v[7] === 1'b1 && n < 20) begin
			d = 16'($urandom);
			a = 26'($urandom) & 26'h3fffff;
			exp_q.push_back({OP_PROGRAM, a[24:0], d});
			prog(a, d);
			cmd(0, CMD_READ_STATUS);
			host.rd(0, v);
			n++;
		end
		check(n >= FIFO_DEPTH, 1'b1);
		prog(26'h100, 16'hbeef);
		st(16'h0010);
		repeat (200) begin
			host.step(1);
			op_ready = 1'($urandom_range(1, 0));
		end
		op_ready = 1'b1;
		host.step(20);
		check(exp_q.size() == 0, 1'b1);
		st(16'h0090);
		cmd(0, CMD_CLEAR_STATUS);
		cmd(0, CMD_LOCK_SETUP);
		cmd(0, CMD_LOCK);
		prog(26'h1, 16'h0001);
		st(16'h0092);
		cmd(0, CMD_CLEAR_STATUS);
		$display("test 4 done");
		// Hold polarity from config bit 10, then a synchronous burst
		cmd(26'h8400, CMD_LOCK_SETUP);
		cmd(26'h8400, CMD_SET_RCR);
		cmd(0, CMD_READ_CFG);
		host.rd(0, v);
		check(v, 16'h8400);
		cmd(0, CMD_READ_ARRAY);
		host.drive.addr = 26'h55;
		host.sel(0, 0);
		host.step(8);
		check({hold_oe_n_ff, hold_ff}, 2'b00);
		host.sel(1, 1);
		cmd(26'h0400, CMD_LOCK_SETUP);
		cmd(26'h0400, CMD_SET_RCR);
		cmd(0, CMD_READ_ARRAY);
		a = 26'($urandom);
		host.drive.addr = a;
		host.sel(0, 0);
		for (int k = 1; k <= 6; k++) begin
			host.lpulse();
			host.drive.addr = ~a;
			if (k < 5)
				check({hold_oe_n_ff, hold_ff}, 2'b01);
			else
				check({hold_ff, dq_out_ff}, {1'b0, arr(25'(a[24:0] + k - 5))});
		end
		host.sel(1, 1);
		$display("test 5 done");
		// Pin reset floats outputs, blocks writes, returns to async array read
		host.drive.pin_reset_n = 1'b0;
		host.sel(0, 0);
		host.step(6);
		check({dq_oe_n_ff, hold_oe_n_ff}, 2'b11);
		host.sel(1, 1);
		prog(26'h2, 16'h0bad);
		host.drive.pin_reset_n = 1'b1;
		a = 26'($urandom);
		host.drive.addr = a;
		host.step(6);
		host.sel(0, 0);
		host.step(8);
		check({hold_oe_n_ff, hold_ff, dq_out_ff}, {2'b01, arr(a[24:0])});
		host.sel(1, 1);
		// Core reset in mid-run, status must come back at its reset value
		reset = 1'b1;
		host.step(2);
		reset = 1'b0;
		host.step(6);
		st(16'h0080);
		$display("test 6 done");
		report_and_stop();
	end
endmodule
`default_nettype wire
